// ### hw/epf_bus.sv
// external program fetch bus controller: fetch select, address latch,
// multiplexed low address/data port, high address port, program read strobe
// assumes the core issues one request at a time and waits for done
// Contract
// - select low forces all fetches external
// - select high: internal below 32 KB only
// - read strobe pulses; memory drives during it
// - no read strobe for internal accesses
// - latch strobe captures low address byte
// - reset pin held two machine cycles resets
// - low port multiplexes address and data
// - high port carries upper address byte
// - machine cycle equals four clocks
`timescale 1ns/100ps
`include "epf_regs.svh"

module epf_bus #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             rst_pin_i,
  // fetch select pin, active low
  input  wire logic             ext_fetch_select_n_i,
  // core request
  input  wire logic             req_i,
  input  epf_pkg::epf_kind_t    kind_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic                  ready_o,
  output logic                  done_o,
  output logic [7:0]            code_o,
  output logic                  is_external_o,
  output logic                  dev_rst_o,
  // external bus pins
  output logic                  addr_latch_strobe_o,
  output logic                  program_read_strobe_n_o,
  output logic [7:0]            high_addr_port_o,
  output logic [7:0]            low_addr_data_port_o,
  output logic                  low_addr_data_port_oe_o,
  input  wire logic [7:0]       low_addr_data_port_i
);
  import epf_pkg::*;

  // the pin split is one byte per port, so only a 16-bit address is served
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("epf_bus: ADDR_W must be 16");
  end

  // the internal space must end exactly at the bit that the decode tests
  if ((32'h1 << `EPF_INT_TOP_BIT) != `EPF_INT_ROM_BYTES) begin : g_bad_int_space
    $error("epf_bus: internal space does not match the decode bit");
  end

  epf_state_t  state_r;
  logic [1:0]  phase_r;
  logic [15:0] addr_r;
  epf_kind_t   kind_r;
  logic        done_r;
  logic [7:0]  code_r;
  logic        ext_r;
  logic        ale_r;
  logic        program_read_strobe_n_r;
  logic        oe_r;
  logic [7:0]  lo_r;
  logic [7:0]  hi_r;
  logic        dev_rst;
  logic        take;
  logic        go_out;

  // decide whether an access leaves the chip
  function automatic logic epf_goes_out(input logic sel_n, input logic [15:0] a);
    if (!sel_n) begin
      return 1'b1;
    end
    return a[`EPF_INT_TOP_BIT];
  endfunction : epf_goes_out

  // pin reset is qualified before it can reach the bus
  epf_reset_filter u_rst (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_pin_i (rst_pin_i),
    .dev_rst_o (dev_rst)
  );

  // request decode shared by sequencer, pin drivers and sampler
  always_comb begin
    take   = 1'b0;
    go_out = 1'b0;
    if (state_r == EPF_IDLE && !dev_rst && req_i) begin
      take   = 1'b1;
      go_out = epf_goes_out(ext_fetch_select_n_i, addr_i);
    end
  end

  // a request is taken only while idle
  assign ready_o = (state_r == EPF_IDLE) && !dev_rst;
  assign dev_rst_o = dev_rst;
  assign done_o = done_r;
  assign code_o = code_r;
  assign is_external_o = ext_r;
  assign addr_latch_strobe_o = ale_r;
  assign program_read_strobe_n_o = program_read_strobe_n_r;
  assign low_addr_data_port_oe_o = oe_r;
  assign low_addr_data_port_o = lo_r;
  assign high_addr_port_o = hi_r;

  // machine cycle phase, one state per clock
  // phase resets while idle so every access starts on a cycle boundary
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_r <= `EPF_PH_ADDR;
    end else if (dev_rst || state_r == EPF_IDLE) begin
      phase_r <= `EPF_PH_ADDR;
    end else begin
      phase_r <= phase_r + 2'd1;
    end
  end

  // sequencer; internal accesses finish in one clock with no bus activity
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= EPF_IDLE;
      addr_r  <= 16'h0000;
      kind_r  <= EPF_KIND_FETCH;
      ext_r   <= 1'b0;
    end else if (dev_rst) begin
      state_r <= EPF_IDLE;
      ext_r   <= 1'b0;
    end else begin
      case (state_r)
        EPF_IDLE: begin
          if (take) begin
            addr_r <= addr_i;
            kind_r <= kind_i;
            ext_r  <= go_out;
            if (go_out) begin
              state_r <= EPF_ADDR;
            end
          end
        end
        EPF_ADDR: begin
          state_r <= EPF_FLOAT;
        end
        EPF_FLOAT: begin
          state_r <= EPF_READ;
        end
        EPF_READ: begin
          if (phase_r == `EPF_PH_STROBE) begin
            state_r <= EPF_IDLE;
          end
        end
        default: begin
          state_r <= EPF_IDLE;
        end
      endcase
    end
  end

  // pin drivers, registered so strobes are glitch free
  // ale falls as the port is released: the board latch must close on that edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ale_r    <= 1'b0;
      program_read_strobe_n_r <= 1'b1;
      oe_r     <= 1'b0;
      lo_r     <= 8'h00;
      hi_r     <= 8'h00;
    end else if (dev_rst) begin
      ale_r    <= 1'b0;
      program_read_strobe_n_r <= 1'b1;
      oe_r     <= 1'b0;
    end else begin
      ale_r    <= 1'b0;
      program_read_strobe_n_r <= 1'b1;
      oe_r     <= 1'b0;
      if (take && go_out) begin
        ale_r <= 1'b1;
        oe_r  <= 1'b1;
        lo_r  <= addr_i[7:0];
        hi_r  <= addr_i[15:8];
      end else if (state_r == EPF_ADDR) begin
        oe_r <= 1'b0;
      end else if (state_r == EPF_FLOAT) begin
        program_read_strobe_n_r <= 1'b0;
      end
    end
  end

  // sample at strobe trailing edge
  // code byte holds for internal accesses; the core reads its own rom
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_r <= 8'h00;
      done_r <= 1'b0;
    end else if (dev_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == EPF_READ) begin
        // memory drives only while strobe low; caught as it rises
        code_r <= low_addr_data_port_i;
        done_r <= 1'b1;
      end else if (take && !go_out) begin
        // internal: core reads its own ROM, bus stays quiet
        done_r <= 1'b1;
      end
    end
  end
endmodule : epf_bus

// ### shared/epf_regs.svh
// timing and field constants for the external program fetch bus
// assumes a 10 MHz core clock, four clocks per machine cycle
`ifndef EPF_REGS_SVH
`define EPF_REGS_SVH

`define EPF_CLKS_PER_MC   3'd4
`define EPF_RST_MC        2'd2
`define EPF_RST_CLKS      4'd8
`define EPF_INT_ROM_BYTES 17'h08000
`define EPF_INT_TOP_BIT   15
`define EPF_PH_ADDR       2'd0
`define EPF_PH_RELEASE    2'd1
`define EPF_PH_STROBE     2'd2
`define EPF_PH_SAMPLE     2'd3

`endif

// ### shared/epf_pkg.sv
// types for the external program fetch bus
// assumes epf_regs.svh is on the include path
package epf_pkg;
  // bus sequencer states, gray along the normal path
  typedef enum logic [1:0] {
    EPF_IDLE  = 2'b00,
    EPF_ADDR  = 2'b01,
    EPF_FLOAT = 2'b11,
    EPF_READ  = 2'b10
  } epf_state_t;

  // kind of program access requested by the core
  typedef enum logic [0:0] {
    EPF_KIND_FETCH = 1'b0,
    EPF_KIND_TABLE = 1'b1
  } epf_kind_t;
endpackage : epf_pkg

// ### hw/epf_reset_filter.sv
// reset qualifier: requires the reset pin high for two machine cycles
// assumes the reset pin is synchronous to clk_i
`timescale 1ns/100ps
`include "epf_regs.svh"

module epf_reset_filter (
  // clock and power-on reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // reset pin and qualified reset
  input  wire logic rst_pin_i,
  output logic      dev_rst_o
);
  logic [3:0] hold_cnt_r;
  logic       dev_rst_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_cnt_r <= 4'h0;
    end else if (!rst_pin_i) begin
      hold_cnt_r <= 4'h0;
    end else if (hold_cnt_r != `EPF_RST_CLKS) begin
      hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dev_rst_r <= 1'b1;
    end else begin
      dev_rst_r <= rst_pin_i && (hold_cnt_r == `EPF_RST_CLKS - 4'h1 || hold_cnt_r == `EPF_RST_CLKS);
    end
  end

  // short pulses are filtered, glitches never reset the bus
  assign dev_rst_o = dev_rst_r;
endmodule : epf_reset_filter

// ### bench/epf_rom_model.sv
// external program rom behind an address latch
// assumes the bench resolves the shared port from both enables
`timescale 1ns/100ps

module epf_rom_model (
  // strobes and buses
  input  wire logic       ale_i,
  input  wire logic       program_read_strobe_n_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] lo_i,
  output logic      [7:0] q_o,
  output logic            oe_o
);
  logic [7:0] lat_r;
  always_latch begin
    if (ale_i) lat_r <= lo_i;
  end
  assign oe_o = !program_read_strobe_n_i;
  assign q_o  = lat_r ^ hi_i ^ 8'h5A; // contents tied to address
endmodule : epf_rom_model

// ### bench/epf_bus_assertions.sv
// pin and handshake checker for the program fetch bus
// assumes it is bound to epf_bus and sees its ports only
`timescale 1ns/100ps

module epf_bus_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_i, sys_rst_i, rst_pin_i, ext_fetch_select_n_i, req_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              ready_o, done_o, is_external_o, dev_rst_o,
  input wire logic [7:0]        code_o, high_addr_port_o, low_addr_data_port_o, low_addr_data_port_i,
  input wire logic              addr_latch_strobe_o, program_read_strobe_n_o, low_addr_data_port_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence tk_ext_s;
    req_i && ready_o && (!ext_fetch_select_n_i || addr_i[15]);
  endsequence
  sequence walk_s;
    addr_latch_strobe_o && low_addr_data_port_oe_o && low_addr_data_port_o == $past(addr_i[7:0])
    && high_addr_port_o == $past(addr_i[15:8]) ##1 !addr_latch_strobe_o && !low_addr_data_port_oe_o
    ##1 !program_read_strobe_n_o ##1 program_read_strobe_n_o && done_o;
  endsequence
  ext_walk_a: assert property (tk_ext_s |=> walk_s) else $error("external walk");
  int_quiet_a: assert property (req_i && ready_o && ext_fetch_select_n_i && !addr_i[15] |=> done_o
    && !is_external_o && program_read_strobe_n_o && !addr_latch_strobe_o) else $error("internal access");
  sel_low_a: assert property (req_i && ready_o && !ext_fetch_select_n_i |=> ##3 is_external_o)
    else $error("select low");
  program_read_strobe_pulse_a: assert property ($fell(program_read_strobe_n_o) |=> $rose(program_read_strobe_n_o))
    else $error("strobe width");
  code_samp_a: assert property ($rose(program_read_strobe_n_o) |-> code_o == $past(low_addr_data_port_i))
    else $error("code sample");
  no_clash_a: assert property (!(low_addr_data_port_oe_o && !program_read_strobe_n_o))
    else $error("port clash");
  four_clk_a: assert property ($rose(addr_latch_strobe_o) |-> !done_o[*3] ##1 done_o)
    else $error("cycle length");
  rst_hold_a: assert property (rst_pin_i[*8] ##1 rst_pin_i ##1 rst_pin_i |-> dev_rst_o)
    else $error("reset hold");
  rst_rel_a: assert property (!rst_pin_i |=> !dev_rst_o) else $error("reset release");
endmodule : epf_bus_assertions

bind epf_bus epf_bus_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### bench/test_ext_program_fetch_bus.sv
// bench for the program fetch bus: reset pin, corner and random accesses
// assumes the rom model and the bound checker are compiled alongside
`timescale 1ns/100ps

module test_ext_program_fetch_bus;
  import epf_pkg::*;
  logic        clk = 0, rst = 1, pin = 0, sel_n = 1, req = 0;
  logic        rdy, done, ext, drst, ale, program_read_strobe_n, oe, rom_oe;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  port, hi, lo, rom_q, code, last_r = 8'hA5;
  logic [31:0] lfsr = 32'h6A012C61;
  epf_kind_t   kind = EPF_KIND_FETCH;
  int          fail_count = 0, checks = 0;
  localparam logic [15:0] COR [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
  epf_bus u_dut (.clk_i(clk), .sys_rst_i(rst), .rst_pin_i(pin), .ext_fetch_select_n_i(sel_n), .req_i(req),
    .kind_i(kind), .addr_i(addr), .ready_o(rdy), .done_o(done), .code_o(code), .is_external_o(ext),
    .dev_rst_o(drst), .addr_latch_strobe_o(ale), .program_read_strobe_n_o(program_read_strobe_n), .high_addr_port_o(hi),
    .low_addr_data_port_o(lo), .low_addr_data_port_oe_o(oe), .low_addr_data_port_i(port));
  epf_rom_model u_rom (.ale_i(ale), .program_read_strobe_n_i(program_read_strobe_n), .hi_i(hi), .lo_i(port), .q_o(rom_q), .oe_o(rom_oe));
  // bus settles 2 ns after an edge, so the latch closes on ale before the address leaves
  // undriven port toggles so stale data never looks valid
  assign #2 port = oe ? lo : (rom_oe ? rom_q : ~last_r);
  always @(posedge clk) last_r <= port;
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] rom(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : rom
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic pulse(int n, logic e);
    pin = 1;
    repeat (n) @(posedge clk) #1;
    chk("dev_rst", e, drst);
    pin = 0;
    repeat (2) @(posedge clk) #1;
    chk("dev_rst", 0, drst);
  endtask : pulse
  // one access; the wait is bounded, done sampled after each edge
  task automatic access(logic s, logic [15:0] a);
    int lat;
    int rd;
    logic e;
    logic [7:0] old;
    lat = 1;
    rd = 0;
    e = !s || a[15];
    old = code;
    chk("ready", 1, rdy);
    sel_n = s;
    addr = a;
    kind = epf_kind_t'(lfsr[4]);
    req = 1;
    @(posedge clk) #1;
    req = 0;
    while (done !== 1'b1 && lat < 20) begin
      rd += (program_read_strobe_n === 1'b0);
      @(posedge clk) #1;
      lat++;
    end
    if (lat == 20) begin
      chk("done_timeout", 1, done);
      summarize();
    end else begin
      chk("latency", e ? 4 : 1, lat);
      chk("read_strobe", e, rd);
      chk("external", e, ext);
      if (e) chk("code", rom(a), code);
      else chk("code_hold", old, code);
      // one idle edge so req never drops and rises in one time step
      @(posedge clk) #1;
    end
  endtask : access
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    pulse(7, 0);
    pulse(12, 1);
    pulse(8, 1);
    for (int i = 0; i < 8; i++) access(i[0], COR[i[2:1]]);
    for (int i = 0; i < 60; i++) begin
      lfsr = nxt(lfsr);
      access(lfsr[3:0] != 4'h0, lfsr[31:16]);
    end
    summarize();
  end
endmodule : test_ext_program_fetch_bus
